/* File: core/dtc_regs.vh */
// Purpose: Register addresses, field positions, reset values and timing counts
//          for the dual timer/counter unit.
// Assumes: Eight-bit special function register space, one clock domain.
// Notes:   Definitions only.
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// Register addresses
`define DTC_ADDR_POWER_CONTROL 8'h87
`define DTC_ADDR_RUN_FLAGS 8'h88
`define DTC_ADDR_MODE_SELECT 8'h89
`define DTC_ADDR_T0_LOW 8'h8a
`define DTC_ADDR_T1_LOW 8'h8b
`define DTC_ADDR_T0_HIGH 8'h8c
`define DTC_ADDR_T1_HIGH 8'h8d

// Power control fields
`define DTC_PC_SMOD 7
`define DTC_PC_STOP 1
`define DTC_PC_IDLE 0
`define DTC_PC_USED_MASK 8'h83

// Run and flags fields
`define DTC_RF_T1_OVF 7
`define DTC_RF_T1_RUN 6
`define DTC_RF_T0_OVF 5
`define DTC_RF_T0_RUN 4
`define DTC_RF_INT1_FLAG 3
`define DTC_RF_INT1_TYPE 2
`define DTC_RF_INT0_FLAG 1
`define DTC_RF_INT0_TYPE 0

// Mode select fields
`define DTC_MS_T1_GATE 7
`define DTC_MS_T1_CNT 6
`define DTC_MS_T1_MODE_HI 5
`define DTC_MS_T1_MODE_LO 4
`define DTC_MS_T0_GATE 3
`define DTC_MS_T0_CNT 2
`define DTC_MS_T0_MODE_HI 1
`define DTC_MS_T0_MODE_LO 0

// Mode codes
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// Reset values
`define DTC_RST_POWER_CONTROL 8'h00
`define DTC_RST_RUN_FLAGS 8'h00
`define DTC_RST_MODE_SELECT 8'h00
`define DTC_RST_COUNT 8'h00

// Timing: processor clocks per timer increment
`define DTC_PRESCALE_DIV 4'hc
`define DTC_PRESCALE_LAST 4'hb

`endif

/* File: core/dtc_fall_detect.v */
// Purpose: Samples a synchronous level and reports a high-to-low transition.
// Assumes: Input is synchronous to clk; idle level is high.
// Notes:   A fall is reported one clock edge after the input drops.
`timescale 1ns/1ns

module dtc_fall_detect (
  input wire clk,
  input wire rst,
  input wire level_in,
  output wire level_now,
  output wire fall
);

  reg sample;
  reg sample_prev;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sample <= 1'b1;
      sample_prev <= 1'b1;
    end else begin
      sample <= level_in;
      sample_prev <= sample;
    end
  end

  assign level_now = sample;
  assign fall = sample_prev & ~sample;

endmodule // dtc_fall_detect

/* File: core/dtc_timer_unit.v */
// Purpose: Two 16-bit timer/counters with run, gate, mode and overflow
//          flags, plus external interrupt 0/1 flags, on an SFR port.
// Assumes: All inputs synchronous to clk; one clock per machine cycle.
// Notes:   Reads return data on the edge after the read strobe.
`timescale 1ns/1ns
`include "dtc_regs.vh"

// Notes on behaviour
// - Timer operation adds one every twelve processor clocks while running.
// - Counter operation adds one per detected falling edge on the count input.
// - Falling edge recognised after two cycles; count rate up to half clock.
// - Each timer counts only while its run bit is set, else holds.
// - Two-bit mode field per timer: 13-bit, 16-bit, auto-reload, special.
// - 13-bit mode uses five low-byte bits plus high byte; upper three zero.
// - Auto-reload increments low byte; on overflow copies high byte into it.
// - Mode 3 stops timer 1; timer 0 becomes two eight-bit counters.
// - Split low byte uses timer 0 controls; high byte timer 1 run and flag.
// - Gate and run set: count falling edges of routed DIO gate signal.
// - Select bit one chooses counter operation, zero chooses timer.
// - Overflow sets flag; software clears it, interrupt service clears it.
// - Falling edge on interrupt input sets edge flag; service clears it.
// - Per-input type bit picks edge or low level triggering.
// - Type bit zero means low level, one means falling edge.
// - Stop bit halts timers until an external interrupt arrives.
module dtc_timer_unit (
  input wire clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  input wire timer_zero_count_input,
  input wire timer_one_count_input,
  input wire timer_zero_gate_input,
  input wire timer_one_gate_input,
  input wire ext_int_zero_n,
  input wire ext_int_one_n,
  input wire timer_zero_ack,
  input wire timer_one_ack,
  input wire ext_int_zero_ack,
  input wire ext_int_one_ack,
  output reg timer_zero_overflow_flag,
  output reg timer_one_overflow_flag,
  output reg ext_int_zero_edge_flag,
  output reg ext_int_one_edge_flag,
  output reg peripherals_stopped
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg [7:0] power_control;
  reg [7:0] timer_mode_select;
  reg timer_zero_run;
  reg timer_one_run;
  reg ext_int_zero_type;
  reg ext_int_one_type;
  reg [7:0] timer_zero_low_byte;
  reg [7:0] timer_zero_high_byte;
  reg [7:0] timer_one_low_byte;
  reg [7:0] timer_one_high_byte;
  reg [3:0] prescale;

  wire [7:0] timer_run_and_flags;
  assign timer_run_and_flags = {timer_one_overflow_flag, timer_one_run,
                                timer_zero_overflow_flag, timer_zero_run,
                                ext_int_one_edge_flag, ext_int_one_type,
                                ext_int_zero_edge_flag, ext_int_zero_type};

  ////////////////////////////////////////////////////////////////////////////
  // Input edge detection

  // Order: count0, count1, gate0, gate1, int0, int1
  wire [5:0] raw_in;
  wire [5:0] level_s;
  wire [5:0] falls;
  assign raw_in = {ext_int_one_n, ext_int_zero_n, timer_one_gate_input,
                   timer_zero_gate_input, timer_one_count_input,
                   timer_zero_count_input};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_fall
      dtc_fall_detect u_fall (
        .clk(clk),
        .rst(rst),
        .level_in(raw_in[gi]),
        .level_now(level_s[gi]),
        .fall(falls[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and counting helpers

  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input we;
    begin
      wr_hit = we & (addr == target);
    end
  endfunction

  // Returns {overflow, high, low} after one increment in modes 0-2; mode 3 returns inputs unchanged
  function [16:0] count_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg [5:0] low5;
    reg [8:0] high9;
    reg [16:0] full;
    reg [8:0] low9;
    begin
      low5 = {1'b0, lo[4:0]} + 6'h01;
      high9 = {1'b0, hi} + {8'h00, low5[5]};
      full = {1'b0, hi, lo} + 17'h00001;
      low9 = {1'b0, lo} + 9'h001;
      case (mode)
        // 13-bit count, upper low-byte bits zero
        `DTC_MODE_13BIT: count_step = {high9[8], high9[7:0], 3'h0, low5[4:0]};
        `DTC_MODE_16BIT: count_step = full;
        // Reload low byte from high byte
        `DTC_MODE_RELOAD: count_step = low9[8] ? {1'b1, hi, hi} : {1'b0, hi, low9[7:0]};
        default: count_step = {1'b0, hi, lo};
      endcase
    end
  endfunction

  wire w_pc;
  wire w_rf;
  wire w_ms;
  wire w_t0l;
  wire w_t0h;
  wire w_t1l;
  wire w_t1h;
  assign w_pc = wr_hit(sfr_addr, `DTC_ADDR_POWER_CONTROL, sfr_wr);
  assign w_rf = wr_hit(sfr_addr, `DTC_ADDR_RUN_FLAGS, sfr_wr);
  assign w_ms = wr_hit(sfr_addr, `DTC_ADDR_MODE_SELECT, sfr_wr);
  assign w_t0l = wr_hit(sfr_addr, `DTC_ADDR_T0_LOW, sfr_wr);
  assign w_t0h = wr_hit(sfr_addr, `DTC_ADDR_T0_HIGH, sfr_wr);
  assign w_t1l = wr_hit(sfr_addr, `DTC_ADDR_T1_LOW, sfr_wr);
  assign w_t1h = wr_hit(sfr_addr, `DTC_ADDR_T1_HIGH, sfr_wr);

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation

  wire stop_bit;
  wire presc_tick;
  wire [1:0] t0_mode;
  wire [1:0] t1_mode;
  wire t0_split;
  wire t0_tick;
  wire t1_tick;
  wire th0_tick;
  assign stop_bit = power_control[`DTC_PC_STOP];
  assign t0_mode = timer_mode_select[`DTC_MS_T0_MODE_HI:`DTC_MS_T0_MODE_LO];
  assign t1_mode = timer_mode_select[`DTC_MS_T1_MODE_HI:`DTC_MS_T1_MODE_LO];
  assign t0_split = (t0_mode == `DTC_MODE_SPLIT);

  assign presc_tick = (prescale == `DTC_PRESCALE_LAST);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale <= 4'h0;
    end else if (stop_bit) begin
      prescale <= prescale;
    end else if (presc_tick) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  // Source per timer: gate edges, count-input edges, or prescaled clock
  function src_tick;
    input gate;
    input cnt_sel;
    input gate_fall;
    input cnt_fall;
    input ptick;
    begin
      // Gate counts routed DIO falling edges
      if (gate)
        src_tick = gate_fall;
      else if (cnt_sel)
        src_tick = cnt_fall;
      else
        src_tick = ptick;
    end
  endfunction

  // Run bit gates counting; stop bit halts all
  assign t0_tick = timer_zero_run & ~stop_bit &
                   src_tick(timer_mode_select[`DTC_MS_T0_GATE],
                            timer_mode_select[`DTC_MS_T0_CNT],
                            falls[2], falls[0], presc_tick);
  assign t1_tick = timer_one_run & ~stop_bit &
                   src_tick(timer_mode_select[`DTC_MS_T1_GATE],
                            timer_mode_select[`DTC_MS_T1_CNT],
                            falls[3], falls[1], presc_tick);
  // Split high byte runs on timer 1 run bit
  assign th0_tick = t0_split & timer_one_run & ~stop_bit & presc_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  wire [16:0] t0_next;
  wire [16:0] t1_next;
  wire [8:0] tl0_split;
  wire [8:0] th0_split;
  assign t0_next = count_step(t0_mode, timer_zero_low_byte, timer_zero_high_byte);
  assign t1_next = count_step(t1_mode, timer_one_low_byte, timer_one_high_byte);
  assign tl0_split = {1'b0, timer_zero_low_byte} + 9'h001;
  assign th0_split = {1'b0, timer_zero_high_byte} + 9'h001;

  wire t0_ovf;
  wire t1_ovf;
  wire th0_ovf;
  // Split low byte raises timer 0 flag
  assign t0_ovf = t0_tick & (t0_split ? tl0_split[8] : t0_next[16]);
  assign th0_ovf = th0_tick & th0_split[8];
  // Timer 1 in mode 3 holds; while timer 0 is split, timer 1 flag is taken by split high byte
  assign t1_ovf = t0_split ? th0_ovf : (t1_tick & t1_next[16]);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_zero_low_byte <= `DTC_RST_COUNT;
      timer_zero_high_byte <= `DTC_RST_COUNT;
      timer_one_low_byte <= `DTC_RST_COUNT;
      timer_one_high_byte <= `DTC_RST_COUNT;
    end else begin
      if (w_t0l)
        timer_zero_low_byte <= sfr_wdata;
      else if (t0_tick)
        timer_zero_low_byte <= t0_split ? tl0_split[7:0] : t0_next[7:0];
      if (w_t0h)
        timer_zero_high_byte <= sfr_wdata;
      else if (th0_tick)
        timer_zero_high_byte <= th0_split[7:0];
      else if (t0_tick & ~t0_split)
        timer_zero_high_byte <= t0_next[15:8];
      // Timer 1 stops in mode 3 via count_step hold
      if (w_t1l)
        timer_one_low_byte <= sfr_wdata;
      else if (t1_tick)
        timer_one_low_byte <= t1_next[7:0];
      if (w_t1h)
        timer_one_high_byte <= sfr_wdata;
      else if (t1_tick)
        timer_one_high_byte <= t1_next[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and flags

  wire int0_set;
  wire int1_set;
  // Type selects edge or level; zero is low level
  assign int0_set = ext_int_zero_type ? falls[4] : ~level_s[4];
  assign int1_set = ext_int_one_type ? falls[5] : ~level_s[5];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      power_control <= `DTC_RST_POWER_CONTROL;
      timer_mode_select <= `DTC_RST_MODE_SELECT;
      timer_zero_run <= 1'b0;
      timer_one_run <= 1'b0;
      ext_int_zero_type <= 1'b0;
      ext_int_one_type <= 1'b0;
      timer_zero_overflow_flag <= 1'b0;
      timer_one_overflow_flag <= 1'b0;
      ext_int_zero_edge_flag <= 1'b0;
      ext_int_one_edge_flag <= 1'b0;
      peripherals_stopped <= 1'b0;
    end else begin
      // External interrupt releases stop; wins over a write
      if (int0_set | int1_set) begin
        power_control[`DTC_PC_STOP] <= 1'b0;
        power_control[`DTC_PC_SMOD] <= w_pc ? sfr_wdata[`DTC_PC_SMOD] :
                                       power_control[`DTC_PC_SMOD];
        power_control[`DTC_PC_IDLE] <= w_pc ? sfr_wdata[`DTC_PC_IDLE] :
                                       power_control[`DTC_PC_IDLE];
      end else if (w_pc) begin
        power_control <= sfr_wdata & `DTC_PC_USED_MASK;
      end
      peripherals_stopped <= stop_bit & ~(int0_set | int1_set) &
                             ~(w_pc & ~sfr_wdata[`DTC_PC_STOP]) |
                             (w_pc & sfr_wdata[`DTC_PC_STOP] &
                              ~(int0_set | int1_set));
      if (w_ms)
        timer_mode_select <= sfr_wdata;
      if (w_rf) begin
        timer_one_run <= sfr_wdata[`DTC_RF_T1_RUN];
        timer_zero_run <= sfr_wdata[`DTC_RF_T0_RUN];
        ext_int_one_type <= sfr_wdata[`DTC_RF_INT1_TYPE];
        ext_int_zero_type <= sfr_wdata[`DTC_RF_INT0_TYPE];
      end
      // Overflow flags: set wins over software or service clear
      if (t0_ovf)
        timer_zero_overflow_flag <= 1'b1;
      else if (timer_zero_ack)
        timer_zero_overflow_flag <= 1'b0;
      else if (w_rf)
        timer_zero_overflow_flag <= sfr_wdata[`DTC_RF_T0_OVF];
      if (t1_ovf)
        timer_one_overflow_flag <= 1'b1;
      else if (timer_one_ack)
        timer_one_overflow_flag <= 1'b0;
      else if (w_rf)
        timer_one_overflow_flag <= sfr_wdata[`DTC_RF_T1_OVF];
      // Interrupt flags set by input; cleared on service, or by input high in low-level mode
      if (int0_set)
        ext_int_zero_edge_flag <= 1'b1;
      else if (ext_int_zero_ack | (~ext_int_zero_type))
        ext_int_zero_edge_flag <= 1'b0;
      else if (w_rf)
        ext_int_zero_edge_flag <= sfr_wdata[`DTC_RF_INT0_FLAG];
      if (int1_set)
        ext_int_one_edge_flag <= 1'b1;
      else if (ext_int_one_ack | (~ext_int_one_type))
        ext_int_one_edge_flag <= 1'b0;
      else if (w_rf)
        ext_int_one_edge_flag <= sfr_wdata[`DTC_RF_INT1_FLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  reg [7:0] next_rdata;

  always @* begin
    case (sfr_addr)
      `DTC_ADDR_POWER_CONTROL: next_rdata = power_control;
      `DTC_ADDR_RUN_FLAGS: next_rdata = timer_run_and_flags;
      `DTC_ADDR_MODE_SELECT: next_rdata = timer_mode_select;
      `DTC_ADDR_T0_LOW: next_rdata = timer_zero_low_byte;
      `DTC_ADDR_T0_HIGH: next_rdata = timer_zero_high_byte;
      `DTC_ADDR_T1_LOW: next_rdata = timer_one_low_byte;
      `DTC_ADDR_T1_HIGH: next_rdata = timer_one_high_byte;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

endmodule // dtc_timer_unit

/* File: test/dtc_timer_sva.sv */
// Purpose: Concurrent checks on the ports of the dual timer/counter unit.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound to every instance of the unit.
`timescale 1ns/1ns

module dtc_timer_sva (
  input wire clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire ext_int_zero_n,
  input wire ext_int_one_n,
  input wire timer_zero_ack,
  input wire ext_int_zero_ack,
  input wire timer_zero_overflow_flag,
  input wire timer_one_overflow_flag,
  input wire ext_int_zero_edge_flag,
  input wire ext_int_one_edge_flag,
  input wire peripherals_stopped
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  chk_unmapped_zero: assert property (sfr_rd && (sfr_addr < 8'h87 || sfr_addr > 8'h8d)
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  chk_power_unused: assert property (sfr_rd && sfr_addr == 8'h87
    |=> sfr_rdata[6:2] == 5'h00) else $error("unused power bits not zero");
  chk_int0_cause: assert property ($rose(ext_int_zero_edge_flag) && !$past(sfr_wr)
    |-> !$past(ext_int_zero_n, 1) || !$past(ext_int_zero_n, 2) || !$past(ext_int_zero_n, 3))
    else $error("int0 flag set without low input");
  chk_int1_cause: assert property ($rose(ext_int_one_edge_flag) && !$past(sfr_wr)
    |-> !$past(ext_int_one_n, 1) || !$past(ext_int_one_n, 2) || !$past(ext_int_one_n, 3))
    else $error("int1 flag set without low input");
  chk_int0_ack: assert property (ext_int_zero_ack && !sfr_wr && $past(ext_int_zero_n)
    |=> !ext_int_zero_edge_flag) else $error("int0 flag not cleared by service");
  chk_t0_ack: assert property (timer_zero_ack && peripherals_stopped && !sfr_wr
    |=> !timer_zero_overflow_flag) else $error("timer0 flag not cleared by service");
  chk_stop_frozen: assert property (peripherals_stopped && $past(peripherals_stopped)
    && !sfr_wr && ext_int_zero_n && ext_int_one_n
    |=> !$rose(timer_zero_overflow_flag) && !$rose(timer_one_overflow_flag))
    else $error("overflow while stopped");
  chk_int_wakes: assert property ($rose(ext_int_zero_edge_flag) && !$past(sfr_wr)
    |-> ##[0:2] !peripherals_stopped) else $error("interrupt did not end stop");

  cov_t0_overflow: cover property ($rose(timer_zero_overflow_flag));
  cov_t1_overflow: cover property ($rose(timer_one_overflow_flag));
  cov_wake: cover property (peripherals_stopped ##[1:20] !peripherals_stopped);
endmodule // dtc_timer_sva

bind dtc_timer_unit dtc_timer_sva dtc_timer_sva_inst (
  .clk(clk),
  .rst(rst),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata),
  .ext_int_zero_n(ext_int_zero_n),
  .ext_int_one_n(ext_int_one_n),
  .timer_zero_ack(timer_zero_ack),
  .ext_int_zero_ack(ext_int_zero_ack),
  .timer_zero_overflow_flag(timer_zero_overflow_flag),
  .timer_one_overflow_flag(timer_one_overflow_flag),
  .ext_int_zero_edge_flag(ext_int_zero_edge_flag),
  .ext_int_one_edge_flag(ext_int_one_edge_flag),
  .peripherals_stopped(peripherals_stopped)
);

/* File: test/dtc_line_src.sv */
// Purpose: Far-side source of one count, gate or interrupt line.
// Assumes: Called at a falling clock edge; line idles high.
// Notes:   Ends with two idle cycles so the last fall is counted.
`timescale 1ns/1ns

module dtc_line_src (
  input wire clk,
  output logic line
);
  initial line = 1'b1;

  task automatic pulses(input int n, input int w);
    repeat (n) begin
      line = 1'b0;
      repeat (w) @(negedge clk);
      line = 1'b1;
      repeat (w) @(negedge clk);
    end
    repeat (2) @(negedge clk);
  endtask
endmodule // dtc_line_src

/* File: test/test_dual_timer_counter_unit.sv */
// Purpose: Self-checking bench for the dual timer/counter unit.
// Assumes: Inputs driven at the falling edge; 50 ns clock.
// Notes:   Mode pairings stay within the allowed set.
`timescale 1ns/1ns

module test_dual_timer_counter_unit;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic t0_ack = 1'b0;
  logic t1_ack = 1'b0;
  logic e0_ack = 1'b0;
  logic e1_ack = 1'b0;
  wire [7:0] sfr_rdata;
  wire cnt0, cnt1, gate0, gate1, int0_n, int1_n;
  wire flag_t0, flag_t1, flag_e0, flag_e1, stopped;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  int i;

  always #25 clk = ~clk;

  dtc_timer_unit dtc_timer_unit_inst (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .timer_zero_count_input(cnt0), .timer_one_count_input(cnt1),
    .timer_zero_gate_input(gate0), .timer_one_gate_input(gate1),
    .ext_int_zero_n(int0_n), .ext_int_one_n(int1_n),
    .timer_zero_ack(t0_ack), .timer_one_ack(t1_ack),
    .ext_int_zero_ack(e0_ack), .ext_int_one_ack(e1_ack),
    .timer_zero_overflow_flag(flag_t0), .timer_one_overflow_flag(flag_t1),
    .ext_int_zero_edge_flag(flag_e0), .ext_int_one_edge_flag(flag_e1),
    .peripherals_stopped(stopped)
  );
  dtc_line_src cnt0_src (.clk(clk), .line(cnt0));
  dtc_line_src cnt1_src (.clk(clk), .line(cnt1));
  dtc_line_src gate0_src (.clk(clk), .line(gate0));
  dtc_line_src gate1_src (.clk(clk), .line(gate1));
  dtc_line_src int0_src (.clk(clk), .line(int0_n));
  dtc_line_src int1_src (.clk(clk), .line(int1_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk8(sfr_rdata, e);
    @(negedge clk);
  endtask

  // Waits for an overflow flag, bounded
  task automatic wait_t(input logic one);
    int k;
    k = 0;
    while ((one ? flag_t1 : flag_t0) !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (i = 8'h87; i <= 8'h8d; i++) rd(i[7:0], 8'h00);
    rd(8'h86, 8'h00);
    rd(8'h90, 8'h00);
    for (i = 0; i < 4; i++) wr(8'h8a + i[7:0], 8'h11 * (i[7:0] + 8'h01));
    for (i = 0; i < 4; i++) rd(8'h8a + i[7:0], 8'h11 * (i[7:0] + 8'h01));
    // Timer mode, 16-bit, from all ones
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    wait_t(1'b0);
    chk1(flag_t0, 1'b1);
    repeat (29) @(negedge clk);
    rd(8'h8a, 8'h02);
    rd(8'h8c, 8'h00);
    wr(8'h88, 8'h00);
    chk1(flag_t0, 1'b0);
    wr(8'h8a, 8'h77);
    repeat (30) @(negedge clk);
    rd(8'h8a, 8'h77);
    // Counter mode at the highest rate
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h88, 8'h10);
    cnt0_src.pulses(6, 1);
    rd(8'h8a, 8'h06);
    // Gated timers 0 and 1 count gate falls
    wr(8'h89, 8'h99);
    wr(8'h8a, 8'h00);
    wr(8'h8b, 8'h00);
    wr(8'h8d, 8'h00);
    wr(8'h88, 8'h50);
    fork
      gate0_src.pulses(2, 2);
      gate1_src.pulses(3, 2);
    join
    rd(8'h8a, 8'h02);
    rd(8'h8b, 8'h03);
    wr(8'h88, 8'h00);
    gate1_src.pulses(2, 1);
    rd(8'h8b, 8'h03);
    // Timer 1 in counter mode
    wr(8'h89, 8'h51);
    wr(8'h88, 8'h40);
    cnt1_src.pulses(2, 1);
    rd(8'h8b, 8'h05);
    // 13-bit carry out of five low bits
    wr(8'h89, 8'h04);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'h00);
    wr(8'h88, 8'h10);
    cnt0_src.pulses(1, 1);
    rd(8'h8a, 8'h00);
    rd(8'h8c, 8'h01);
    // Auto-reload, timer 1 in reload mode too
    wr(8'h89, 8'h26);
    wr(8'h8c, 8'ha5);
    wr(8'h8a, 8'hfe);
    cnt0_src.pulses(2, 1);
    rd(8'h8a, 8'ha5);
    chk1(flag_t0, 1'b1);
    // Split timer 0, timer 1 held
    wr(8'h89, 8'h37);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    wr(8'h8b, 8'h10);
    wr(8'h88, 8'h50);
    chk1(flag_t0, 1'b0);
    wait_t(1'b1);
    chk1(flag_t1, 1'b1);
    cnt0_src.pulses(2, 1);
    chk1(flag_t0, 1'b1);
    rd(8'h8a, 8'h00);
    rd(8'h8b, 8'h10);
    // Stop, service clears, interrupt wakes
    wr(8'h89, 8'h33);
    wr(8'h87, 8'hff);
    rd(8'h87, 8'h83);
    chk1(stopped, 1'b1);
    t0_ack = 1'b1;
    t1_ack = 1'b1;
    @(negedge clk);
    t0_ack = 1'b0;
    t1_ack = 1'b0;
    chk1(flag_t0, 1'b0);
    chk1(flag_t1, 1'b0);
    wr(8'h8a, 8'h40);
    repeat (30) @(negedge clk);
    rd(8'h8a, 8'h40);
    wr(8'h88, 8'h55);
    int0_src.pulses(1, 2);
    chk1(flag_e0, 1'b1);
    chk1(stopped, 1'b0);
    rd(8'h87, 8'h81);
    e0_ack = 1'b1;
    @(negedge clk);
    e0_ack = 1'b0;
    chk1(flag_e0, 1'b0);
    int1_src.pulses(1, 1);
    chk1(flag_e1, 1'b1);
    e1_ack = 1'b1;
    @(negedge clk);
    e1_ack = 1'b0;
    chk1(flag_e1, 1'b0);
    // Low-level type follows the input
    wr(8'h88, 8'h50);
    fork
      int1_src.pulses(1, 6);
      begin
        repeat (4) @(negedge clk);
        chk1(flag_e1, 1'b1);
      end
    join
    chk1(flag_e1, 1'b0);
    stop_test();
  end
endmodule // test_dual_timer_counter_unit
